// *** design/scss_top.sv ***
// system clock source select: oscillator control registers, prescaler and source switch
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - after reset the system clock runs from the internal oscillator
// - eight-bit calibration register, reset value is the factory trim
// - prescaler code 00 divides by 8, 01 by 4, 10 by 2, 11 by 1
// - internal control bit 7 enables the internal oscillator
// - internal control bit 6 reads 1 only while oscillator runs settled
// - source select 0 picks prescaled internal, 1 picks external circuit
// - external clock stays available to timers while internal drives system
// - source may change on the fly; software picks only settled sources
// - one internal control write may enable the internal oscillator and set its prescaler
// - crystal valid flag in bit 7 set once crystal settles, else 0
// - mode field: off, cmos, cmos div2, rc div2, crystal, crystal div2
// - in crystal mode frequency control sets drive band
// - in rc mode frequency control picks the band holding the frequency
// - rc and capacitor modes usable at once, no settling wait
// - external control bit 3 reads zero and ignores writes
module scss_top
  import scss_pkg::*;
#(
  parameter logic [7:0] CAL_TRIM = CAL_TRIM_DEFAULT,
  parameter int INT_RDY_TICKS = INT_RDY_TICKS_DEFAULT,
  parameter int XTAL_SETTLE_EDGES = XTAL_SETTLE_EDGES_DEFAULT
) (
  // clock and reset
  input wire logic REF_CLK,
  input wire logic RSTN,
  // register port
  input wire scss_sfr_req_s SFR_REQ,
  output logic [7:0] SFR_RDATA,
  // oscillator inputs, one-cycle ticks and sampled pin
  input wire logic INT_OSC_TICK,
  input wire logic OSC_PIN_ONE,
  // oscillator analog controls
  output logic INT_OSC_EN,
  output logic [7:0] INT_OSC_CAL,
  output logic [2:0] EXT_MODE,
  output logic [2:0] EXT_FREQ_CTRL,
  // clock enables and status
  output logic SYSCLK_EN,
  output logic EXT_CLK_EN,
  output logic SYSCLK_FROM_EXT
);

  localparam int RDY_W = $clog2(INT_RDY_TICKS + 1);
  localparam int XS_W = $clog2(XTAL_SETTLE_EDGES + 1);
  localparam logic [RDY_W-1:0] RDY_LAST = RDY_W'(INT_RDY_TICKS - 1);
  localparam logic [XS_W-1:0] XS_LAST = XS_W'(XTAL_SETTLE_EDGES - 1);

  // refuse counts the counters cannot serve
  if (INT_RDY_TICKS < 1 || XTAL_SETTLE_EDGES < 1) begin : g_bad_param
    $error("scss_top: settle counts must be at least one");
  end

  logic int_en_q;
  logic [1:0] presc_q;
  logic [7:0] cal_q;
  logic [2:0] ext_mode_q;
  logic [2:0] ext_fc_q;
  logic src_sel_q;
  logic int_rdy_q;
  logic [RDY_W-1:0] rdy_cnt_q;
  logic [2:0] pre_cnt_q;
  logic pin_q;
  logic half_q;
  logic xtal_valid_q;
  logic [XS_W-1:0] xs_cnt_q;
  scss_sw_state_e sw_state_q;
  logic act_sel_q;
  logic sysclk_en_q;
  logic ext_clk_en_q;
  logic [7:0] rdata_q;

  logic wr_int_ctrl;
  logic wr_cal;
  logic int_restart;
  logic int_tick;
  logic [2:0] div_m1;
  logic int_sys_tick;
  logic ext_on;
  logic ext_div2;
  logic ext_edge;
  logic ext_tick;
  logic xtal_mode;
  logic old_tick;
  logic new_tick;
  logic mux_tick;

  assign wr_int_ctrl = SFR_REQ.wr && SFR_REQ.addr == ADDR_INT_CTRL;
  assign wr_cal = SFR_REQ.wr && SFR_REQ.addr == ADDR_INT_CAL;

  // software-visible configuration registers
  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      int_en_q <= INT_CTRL_RST[INT_EN_BIT];
      presc_q <= INT_CTRL_RST[PRESC_LSB +: 2];
      cal_q <= CAL_TRIM;
      ext_mode_q <= EXT_CTRL_RST[EXT_MODE_LSB +: 3];
      ext_fc_q <= EXT_CTRL_RST[EXT_FC_LSB +: 3];
      src_sel_q <= SRC_SEL_RST[SRC_SEL_BIT];
    end else if (SFR_REQ.wr) begin
      if (SFR_REQ.addr == ADDR_INT_CTRL) begin
        // enable and prescale land together in one write
        int_en_q <= SFR_REQ.data[INT_EN_BIT];
        presc_q <= SFR_REQ.data[PRESC_LSB +: 2];
      end else if (SFR_REQ.addr == ADDR_INT_CAL) begin
        cal_q <= SFR_REQ.data;
      end else if (SFR_REQ.addr == ADDR_EXT_CTRL) begin
        // bit 3 and the valid flag are not stored
        ext_mode_q <= SFR_REQ.data[EXT_MODE_LSB +: 3];
        ext_fc_q <= SFR_REQ.data[EXT_FC_LSB +: 3];
      end else if (SFR_REQ.addr == ADDR_SRC_SEL) begin
        src_sel_q <= SFR_REQ.data[SRC_SEL_BIT];
      end
    end
  end

  // calibration output, trim applied until software writes its own
  logic cal_written_q;
  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      cal_written_q <= 1'b0;
    end else if (wr_cal) begin
      cal_written_q <= 1'b1;
    end
  end
  assign INT_OSC_CAL = cal_written_q ? cal_q : CAL_TRIM;

  // ready restarts when the oscillator is turned on or retuned
  assign int_restart = (wr_int_ctrl && SFR_REQ.data[INT_EN_BIT] && !int_en_q) || wr_cal;
  assign int_tick = INT_OSC_TICK && int_en_q;

  // internal ready flag counts settled oscillator ticks
  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      int_rdy_q <= INT_CTRL_RST[INT_RDY_BIT];
      rdy_cnt_q <= '0;
    end else if (!int_en_q || int_restart) begin
      int_rdy_q <= 1'b0;
      rdy_cnt_q <= '0;
    end else if (int_tick && !int_rdy_q) begin
      rdy_cnt_q <= rdy_cnt_q + RDY_W'(1);
      if (rdy_cnt_q == RDY_LAST) begin
        int_rdy_q <= 1'b1;
      end
    end
  end

  // prescaler terminal count per code
  always_comb begin
    case (presc_q)
      PRESC_DIV8: div_m1 = 3'h7;
      PRESC_DIV4: div_m1 = 3'h3;
      PRESC_DIV2: div_m1 = 3'h1;
      default: div_m1 = 3'h0;
    endcase
  end

  // compare with >= so a smaller divisor written mid-count still wraps
  assign int_sys_tick = int_tick && pre_cnt_q >= div_m1;

  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      pre_cnt_q <= 3'h0;
    end else if (int_tick) begin
      pre_cnt_q <= int_sys_tick ? 3'h0 : pre_cnt_q + 3'h1;
    end
  end

  // external mode decode
  assign ext_on = ext_mode_q[2:1] != MODE_FAM_OFF;
  assign xtal_mode = ext_mode_q[2:1] == MODE_FAM_XTAL;
  assign ext_div2 = (ext_mode_q[2:1] == MODE_FAM_RC) || ext_mode_q[0];
  assign ext_edge = ext_on && OSC_PIN_ONE && !pin_q;
  // rc and capacitor edges pass at once, no settle gate
  assign ext_tick = ext_edge && (!ext_div2 || half_q);

  // pin edge detect and divide-by-two stage
  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      pin_q <= 1'b0;
      half_q <= 1'b0;
    end else begin
      pin_q <= OSC_PIN_ONE;
      if (!ext_on) begin
        half_q <= 1'b0;
      end else if (ext_edge) begin
        half_q <= !half_q;
      end
    end
  end

  // crystal valid counts edges while in crystal mode only
  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      xtal_valid_q <= 1'b0;
      xs_cnt_q <= '0;
    end else if (!xtal_mode) begin
      xtal_valid_q <= 1'b0;
      xs_cnt_q <= '0;
    end else if (ext_edge && !xtal_valid_q) begin
      xs_cnt_q <= xs_cnt_q + XS_W'(1);
      if (xs_cnt_q == XS_LAST) begin
        xtal_valid_q <= 1'b1;
      end
    end
  end

  // ticks of the source in use and of the one being switched to
  assign old_tick = act_sel_q ? ext_tick : int_sys_tick;
  assign new_tick = act_sel_q ? int_sys_tick : ext_tick;

  // hand over after an old edge, drop the first new one: no short phase
  always_comb begin
    case (sw_state_q)
      SW_RUN: mux_tick = old_tick;
      SW_WAIT_OLD: mux_tick = old_tick;
      default: mux_tick = 1'b0;
    endcase
  end

  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      sw_state_q <= SW_RUN;
      act_sel_q <= SRC_INTERNAL;
    end else begin
      case (sw_state_q)
        SW_RUN: begin
          if (src_sel_q != act_sel_q) begin
            sw_state_q <= SW_WAIT_OLD;
          end
        end
        SW_WAIT_OLD: begin
          if (src_sel_q == act_sel_q) begin
            sw_state_q <= SW_RUN;
          end else if (old_tick) begin
            sw_state_q <= SW_WAIT_NEW;
          end
        end
        SW_WAIT_NEW: begin
          if (src_sel_q == act_sel_q) begin
            sw_state_q <= SW_RUN;
          end else if (new_tick) begin
            act_sel_q <= src_sel_q;
            sw_state_q <= SW_RUN;
          end
        end
        default: sw_state_q <= SW_RUN;
      endcase
    end
  end

  // registered clock enables; external one runs whatever the selection
  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      sysclk_en_q <= 1'b0;
      ext_clk_en_q <= 1'b0;
    end else begin
      sysclk_en_q <= mux_tick;
      ext_clk_en_q <= ext_tick;
    end
  end

  // read data, reserved bits zero, unmapped reads zero
  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      rdata_q <= 8'h00;
    end else if (SFR_REQ.rd) begin
      if (SFR_REQ.addr == ADDR_INT_CTRL) begin
        // gate with enable: the flag itself clears one cycle after a disable lands
        rdata_q <= {int_en_q, int_rdy_q && int_en_q, 4'h0, presc_q};
      end else if (SFR_REQ.addr == ADDR_INT_CAL) begin
        rdata_q <= INT_OSC_CAL;
      end else if (SFR_REQ.addr == ADDR_EXT_CTRL) begin
        rdata_q <= {xtal_valid_q, ext_mode_q, 1'b0, ext_fc_q};
      end else if (SFR_REQ.addr == ADDR_SRC_SEL) begin
        rdata_q <= {7'h00, src_sel_q};
      end else begin
        rdata_q <= 8'h00;
      end
    end
  end

  assign SFR_RDATA = rdata_q;
  assign INT_OSC_EN = int_en_q;
  assign EXT_MODE = ext_mode_q;
  assign EXT_FREQ_CTRL = ext_fc_q;
  assign SYSCLK_EN = sysclk_en_q;
  assign EXT_CLK_EN = ext_clk_en_q;
  assign SYSCLK_FROM_EXT = act_sel_q;

endmodule

`default_nettype wire

// *** common/scss_pkg.sv ***
// constants, types and register layout for the system clock source select block
package scss_pkg;
  // register addresses on the special function register port
  localparam logic [7:0] ADDR_INT_CTRL = 8'h8a;
  localparam logic [7:0] ADDR_INT_CAL = 8'h8b;
  localparam logic [7:0] ADDR_EXT_CTRL = 8'h8c;
  localparam logic [7:0] ADDR_SRC_SEL = 8'h8d;
  // reset values
  localparam logic [7:0] INT_CTRL_RST = 8'hc0;
  localparam logic [7:0] EXT_CTRL_RST = 8'h00;
  localparam logic [7:0] SRC_SEL_RST = 8'h00;
  localparam logic [7:0] CAL_TRIM_DEFAULT = 8'h80;
  // field positions
  localparam int INT_EN_BIT = 7;
  localparam int INT_RDY_BIT = 6;
  localparam int PRESC_LSB = 0;
  localparam int EXT_VALID_BIT = 7;
  localparam int EXT_MODE_LSB = 4;
  localparam int EXT_FC_LSB = 0;
  localparam int SRC_SEL_BIT = 0;
  // internal prescaler codes
  localparam logic [1:0] PRESC_DIV8 = 2'b00;
  localparam logic [1:0] PRESC_DIV4 = 2'b01;
  localparam logic [1:0] PRESC_DIV2 = 2'b10;
  localparam logic [1:0] PRESC_DIV1 = 2'b11;
  // external mode codes, upper two bits decide the family
  localparam logic [1:0] MODE_FAM_OFF = 2'b00;
  localparam logic [1:0] MODE_FAM_CMOS = 2'b01;
  localparam logic [1:0] MODE_FAM_RC = 2'b10;
  localparam logic [1:0] MODE_FAM_XTAL = 2'b11;
  // timing counts, in oscillator edges
  localparam int INT_RDY_TICKS_DEFAULT = 16;
  localparam int XTAL_SETTLE_EDGES_DEFAULT = 64;
  // source select values
  localparam logic SRC_INTERNAL = 1'b0;
  localparam logic SRC_EXTERNAL = 1'b1;
  // register port request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] data;
  } scss_sfr_req_s;
  // glitch-free switch states
  typedef enum logic [1:0] {
    SW_RUN = 2'b00,
    SW_WAIT_OLD = 2'b01,
    SW_WAIT_NEW = 2'b10
  } scss_sw_state_e;
endpackage

// *** verification/scss_xosc_model.sv ***
// external oscillator model: a crystal or clock on pin one
`timescale 1ns/1ps
`default_nettype none
module scss_xosc_model
  import scss_pkg::*;
(
  // clock, drive settings from the device, wanted band and half period
  input wire logic clk,
  input wire logic [2:0] mode,
  input wire logic [2:0] band,
  input wire logic [2:0] want_band,
  input wire logic [3:0] half,
  // sampled pin level
  output logic pin
);
  int cnt = 0;
  initial pin = 1'b0;
  // a crystal driven in the wrong band never starts, pin rests low
  always @(posedge clk) begin
    if (mode[2:1] == MODE_FAM_OFF || band != want_band) begin
      pin <= 1'b0;
      cnt <= 0;
    end else if (cnt + 1 >= int'(half)) begin
      pin <= ~pin;
      cnt <= 0;
    end else begin
      cnt <= cnt + 1;
    end
  end
endmodule
`default_nettype wire

// *** verification/scss_top_chk.sv ***
// assertions on the clock source select ports
`timescale 1ns/1ps
`default_nettype none
module scss_top_chk
  import scss_pkg::*;
#(
  parameter logic [7:0] CAL_TRIM = CAL_TRIM_DEFAULT,
  parameter int INT_RDY_TICKS = INT_RDY_TICKS_DEFAULT,
  parameter int XTAL_SETTLE_EDGES = XTAL_SETTLE_EDGES_DEFAULT
) (
  // clock and reset
  input wire logic REF_CLK,
  input wire logic RSTN,
  // register port
  input wire scss_sfr_req_s SFR_REQ,
  input wire logic [7:0] SFR_RDATA,
  // oscillator side
  input wire logic INT_OSC_TICK,
  input wire logic OSC_PIN_ONE,
  input wire logic INT_OSC_EN,
  input wire logic [7:0] INT_OSC_CAL,
  input wire logic [2:0] EXT_MODE,
  input wire logic [2:0] EXT_FREQ_CTRL,
  // clock enables
  input wire logic SYSCLK_EN,
  input wire logic EXT_CLK_EN,
  input wire logic SYSCLK_FROM_EXT
);
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RSTN);
  // one register access at a given address
  sequence rd_at(logic [7:0] a);
    SFR_REQ.rd && SFR_REQ.addr == a;
  endsequence
  sequence wr_at(logic [7:0] a);
    SFR_REQ.wr && SFR_REQ.addr == a;
  endsequence
  a_reset_state: assert property ($rose(RSTN) |-> INT_OSC_EN && !SYSCLK_FROM_EXT && EXT_MODE == 3'h0)
    else $error("state after reset wrong");
  a_cal_trim: assert property ($rose(RSTN) |-> INT_OSC_CAL == CAL_TRIM)
    else $error("calibration not at trim");
  a_sel_reserved: assert property (rd_at(ADDR_SRC_SEL) |=> SFR_RDATA[7:1] == 7'h00)
    else $error("select reserved bits set");
  a_bit3_zero: assert property (rd_at(ADDR_EXT_CTRL) |=> !SFR_RDATA[3])
    else $error("external bit 3 reads one");
  a_valid_off: assert property (rd_at(ADDR_EXT_CTRL) ##0 EXT_MODE[2:1] != MODE_FAM_XTAL |=> !SFR_RDATA[7])
    else $error("crystal valid outside crystal mode");
  a_ready_off: assert property (rd_at(ADDR_INT_CTRL) ##0 !INT_OSC_EN |=> !SFR_RDATA[INT_RDY_BIT])
    else $error("ready while disabled");
  a_mode_write: assert property (wr_at(ADDR_EXT_CTRL) |=>
    EXT_MODE == $past(SFR_REQ.data[6:4]) && EXT_FREQ_CTRL == $past(SFR_REQ.data[2:0]))
    else $error("external fields not written");
  a_int_quiet: assert property (!INT_OSC_EN && !SYSCLK_FROM_EXT |=> !SYSCLK_EN)
    else $error("system pulse with oscillator off");
  a_ext_quiet: assert property ((EXT_MODE[2:1] == MODE_FAM_OFF) [*2] |-> !EXT_CLK_EN)
    else $error("external pulse while off");
  a_flip_gap: assert property ($changed(SYSCLK_FROM_EXT) |-> !SYSCLK_EN)
    else $error("pulse passed on handover");
  a_cmos_pass: assert property (EXT_MODE == 3'h2 && OSC_PIN_ONE && !$past(OSC_PIN_ONE) |=> EXT_CLK_EN)
    else $error("cmos edge not passed");
  a_int_tick_gate: assert property (!INT_OSC_TICK && !SYSCLK_FROM_EXT |=> !SYSCLK_EN)
    else $error("internal pulse without a tick");
endmodule
bind scss_top scss_top_chk #(.CAL_TRIM(CAL_TRIM), .INT_RDY_TICKS(INT_RDY_TICKS),
  .XTAL_SETTLE_EDGES(XTAL_SETTLE_EDGES)) u_chk (.REF_CLK(REF_CLK), .RSTN(RSTN),
  .SFR_REQ(SFR_REQ), .SFR_RDATA(SFR_RDATA), .INT_OSC_TICK(INT_OSC_TICK), .OSC_PIN_ONE(OSC_PIN_ONE),
  .INT_OSC_EN(INT_OSC_EN), .INT_OSC_CAL(INT_OSC_CAL), .EXT_MODE(EXT_MODE), .EXT_FREQ_CTRL(EXT_FREQ_CTRL),
  .SYSCLK_EN(SYSCLK_EN), .EXT_CLK_EN(EXT_CLK_EN), .SYSCLK_FROM_EXT(SYSCLK_FROM_EXT));
`default_nettype wire

// *** verification/scss_top_tb_top.sv ***
// self-checking bench for the clock source select block
`timescale 1ns/1ps
`default_nettype none
module scss_top_tb_top;
  import scss_pkg::*;
  logic REF_CLK, RSTN, tick, pin, int_en, sys_en, ext_en, from_ext;
  scss_sfr_req_s req;
  logic [7:0] rdata, cal, d;
  logic [2:0] mode, fc;
  logic [16:0] rnd = 17'd87539;
  logic [7:0] rst_exp [5];
  int error_cnt, n_tests, cyc, tk, s_last, s_gap, s_tk, s_dt, x_last, x_gap, s_n, x_n, gap, i, n;
  // software's wait before polling crystal valid: 1 ms of 25 ns cycles
  localparam int SETTLE_CYC = 40000;
  scss_top #(.INT_RDY_TICKS(2), .XTAL_SETTLE_EDGES(2)) dut (.REF_CLK(REF_CLK), .RSTN(RSTN),
    .SFR_REQ(req), .SFR_RDATA(rdata), .INT_OSC_TICK(tick), .OSC_PIN_ONE(pin), .INT_OSC_EN(int_en),
    .INT_OSC_CAL(cal), .EXT_MODE(mode), .EXT_FREQ_CTRL(fc), .SYSCLK_EN(sys_en),
    .EXT_CLK_EN(ext_en), .SYSCLK_FROM_EXT(from_ext));
  scss_xosc_model u_xosc (.clk(REF_CLK), .mode(mode), .band(fc), .want_band(3'h5),
    .half(4'd3), .pin(pin));
  function automatic logic [16:0] lfsr(input logic [16:0] s);
    return {s[15:0], s[16] ^ s[13]};
  endfunction
  initial begin
    REF_CLK = 1'b0;
    forever #12.5 REF_CLK = ~REF_CLK;
  end
  // random tick spacing; period counts are kept in ticks and cycles
  always @(posedge REF_CLK) begin
    rnd <= lfsr(rnd);
    tick <= (gap == 0);
    gap <= (gap == 0) ? int'(rnd[1:0]) + 1 : gap - 1;
    cyc <= cyc + 1;
    if (tick && int_en) tk <= tk + 1;
    if (sys_en) begin
      s_gap <= cyc - s_last;
      s_last <= cyc;
      s_dt <= tk - s_tk;
      s_tk <= tk;
      s_n <= s_n + 1;
    end
    if (ext_en) begin
      x_gap <= cyc - x_last;
      x_last <= cyc;
      x_n <= x_n + 1;
    end
  end
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %s expected %0h seen %0h", nm, exp, got);
    end
  endtask
  // one register access; read data lands in d
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] dat);
    @(posedge REF_CLK);
    req <= '{wr: w, rd: ~w, addr: a, data: dat};
    @(posedge REF_CLK);
    req <= '0;
    @(posedge REF_CLK);
    #1 d = rdata;
  endtask
  task automatic wp(input bit x, input int k);
    int n0, j;
    n0 = x ? x_n : s_n;
    for (j = 0; j < 3000 && (x ? x_n : s_n) < n0 + k; j++) @(posedge REF_CLK);
    chk("pulses", (x ? x_n : s_n) >= n0 + k, 1);
  endtask
  task automatic wf(input logic v);
    int j;
    for (j = 0; j < 500 && from_ext !== v; j++) @(posedge REF_CLK);
    chk("from_ext", from_ext, v);
  endtask
  task automatic end_sim();
    if (error_cnt == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    RSTN = 1'b0;
    req = '0;
    rst_exp = '{INT_CTRL_RST, CAL_TRIM_DEFAULT, EXT_CTRL_RST, SRC_SEL_RST, 8'h00};
    repeat (16) @(posedge REF_CLK);
    RSTN <= 1'b1;
    // reset values, last address unmapped
    for (i = 0; i < 5; i++) begin
      bus(0, ADDR_INT_CTRL + i[7:0], 8'h00);
      chk("reset", d, rst_exp[i]);
    end
    chk("from_ext", from_ext, 1'b0);
    // small random step from the trim keeps the oscillator under its ceiling
    n = int'(CAL_TRIM_DEFAULT) - int'(rnd[5:0]);
    bus(1, ADDR_INT_CAL, n[7:0]);
    chk("cal", cal, n);
    repeat (40) @(posedge REF_CLK);
    bus(0, ADDR_INT_CTRL, 8'h00);
    chk("ready", d, 8'hc0);
    for (i = 0; i < 4; i++) begin
      bus(1, ADDR_INT_CTRL, 8'h80 | i[7:0]);
      wp(0, 3);
      chk("div", s_dt, 8 >> i);
    end
    bus(1, ADDR_INT_CTRL, 8'h03);
    chk("int_en", int_en, 1'b0);
    n = s_n;
    repeat (40) @(posedge REF_CLK);
    chk("off", s_n, n);
    bus(0, ADDR_INT_CTRL, 8'h00);
    chk("ready", d, 8'h03);
    bus(1, ADDR_INT_CTRL, 8'h83);
    wp(0, 3);
    chk("div", s_dt, 1);
    // wrong band: crystal stays silent, flag and bit 3 ignore the write
    bus(1, ADDR_EXT_CTRL, 8'hff);
    chk("ext_fields", {mode, fc}, 6'h3f);
    repeat (40) @(posedge REF_CLK);
    bus(0, ADDR_EXT_CTRL, 8'h00);
    chk("xctl", d, 8'h77);
    for (i = 0; i < 8; i++) begin
      bus(1, ADDR_EXT_CTRL, {1'b0, i[2:0], 4'h5});
      n = x_n;
      if (i < 2) begin
        repeat (60) @(posedge REF_CLK);
        chk("ext_off", x_n, n);
      end else begin
        if (i == 6) repeat (SETTLE_CYC) @(posedge REF_CLK);
        wp(1, 3);
        chk("ext_gap", x_gap, (i == 2 || i == 6) ? 6 : 12);
      end
      bus(0, ADDR_EXT_CTRL, 8'h00);
      chk("valid", d[7], i > 5);
    end
    // hand the system clock to the crystal and back
    bus(1, ADDR_SRC_SEL, 8'h01);
    wf(1'b1);
    wp(0, 3);
    chk("sys_gap", s_gap, 12);
    bus(0, ADDR_SRC_SEL, 8'h00);
    chk("sel", d, 8'h01);
    bus(1, ADDR_SRC_SEL, 8'h00);
    wf(1'b0);
    wp(0, 3);
    chk("div", s_dt, 1);
    end_sim();
  end
  // hang guard, well beyond the expected run
  initial begin
    repeat (60000) @(posedge REF_CLK);
    error_cnt++;
    end_sim();
  end
endmodule
`default_nettype wire
